/* File: hdl/eep_params.svh */
// protocol, layout and timing constants for the serial memory link
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH

`define EEP_DEV_ID          4'ha
`define EEP_ID_MSB          7
`define EEP_ID_LSB          4
`define EEP_UPPER_MSB       3
`define EEP_UPPER_LSB       1
`define EEP_RW_BIT          0
`define EEP_MEM_BYTES       2048
`define EEP_PAGE_BYTES      16
`define EEP_BIT_ACK         4'h8
`define EEP_BIT_TX_LAST     4'h7
`define EEP_RELEASED        8'hff

`define EEP_SYS_PERIOD_NS   8
`define EEP_LINK_PERIOD_NS  64
`define EEP_PROG_TIME_MS    5
`define EEP_PROG_CYCLES     ((`EEP_PROG_TIME_MS * 1000000) / `EEP_LINK_PERIOD_NS)
`define EEP_POWERUP_MS      1
`define EEP_POWERUP_CYCLES  \
   ((`EEP_POWERUP_MS * 1000000 + `EEP_SYS_PERIOD_NS - 1) / `EEP_SYS_PERIOD_NS)
`define EEP_SCL_PERIOD_NS   2500
`define EEP_SCL_QTR_CYCLES  \
   ((`EEP_SCL_PERIOD_NS + 4 * `EEP_SYS_PERIOD_NS - 1) / (4 * `EEP_SYS_PERIOD_NS))

`endif

/* File: hdl/eep_pkg.sv */
// types shared by both ends of the serial memory link
package eep_pkg;

   typedef enum logic [2:0] {
      EEP_OP_START_WR,
      EEP_OP_WRITE,
      EEP_OP_READ_ACK,
      EEP_OP_READ_NACK,
      EEP_OP_STOP
   } eep_op_type;

   typedef enum logic [2:0] {
      EEP_DS_IDLE,
      EEP_DS_RX,
      EEP_DS_RACK,
      EEP_DS_TX,
      EEP_DS_TACK,
      EEP_DS_WAIT
   } eep_dev_state_type;

   typedef enum logic [1:0] {
      EEP_RK_SLAVE,
      EEP_RK_WORD,
      EEP_RK_DATA
   } eep_rx_kind_type;

   typedef enum logic [1:0] {
      EEP_MS_IDLE,
      EEP_MS_START,
      EEP_MS_BIT,
      EEP_MS_STOP
   } eep_mst_state_type;

endpackage : eep_pkg

/* File: hdl/eep_link_if.sv */
// two-wire link between bus master and memory device
`timescale 1ns/1ps
interface eep_link_if;
   logic scl;
   logic sda;
   logic mst_sda_o;
   logic mst_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;

   // wired-and data line with pull-up
   assign sda = ~((~mst_sda_oe_n & ~mst_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

   modport master (output scl, output mst_sda_o, output mst_sda_oe_n, input sda);
   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface : eep_link_if

/* File: hdl/eep_bus_mst.sv */
// bus master end: byte-level command port driving the two-wire link
`timescale 1ns/1ps
`include "eep_params.svh"
module eep_bus_mst #(
   parameter int unsigned POWERUP_CYCLES = `EEP_POWERUP_CYCLES
) (
   input  logic                CLK_SYS,
   input  logic                RSTN,
   input  logic                CMD_VALID,
   output logic                CMD_READY,
   input  eep_pkg::eep_op_type CMD_OP,
   input  logic [7:0]          CMD_DATA,
   output logic                RSP_VALID,
   output logic [7:0]          RSP_DATA,
   output logic                RSP_ACK,
   eep_link_if.master          link
);
   eep_pkg::eep_mst_state_type state_reg;
   eep_pkg::eep_op_type        op_reg;
   logic [16:0]                pwr_cnt_reg;
   logic                       pwr_done_reg;
   logic [6:0]                 q_cnt_reg;
   logic [1:0]                 q_reg;
   logic [3:0]                 bit_idx_reg;
   logic [7:0]                 tx_reg;
   logic [7:0]                 rx_reg;
   logic                       scl_reg;
   logic                       sda_oe_n_reg;
   logic                       rsp_valid_reg;
   logic                       rsp_ack_reg;
   logic                       sda_m_reg;
   logic                       sda_s_reg;
   logic                       tick;
   logic                       cmd_take;

   assign tick      = (state_reg != eep_pkg::EEP_MS_IDLE) &&
                      (q_cnt_reg == 7'(`EEP_SCL_QTR_CYCLES - 1));
   assign CMD_READY = (state_reg == eep_pkg::EEP_MS_IDLE) && pwr_done_reg;
   assign cmd_take  = CMD_VALID && CMD_READY;

   // data line synchroniser
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         sda_m_reg <= 1'b1;
         sda_s_reg <= 1'b1;
      end else begin
         sda_m_reg <= link.sda;
         sda_s_reg <= sda_m_reg;
      end
   end

   // hold off commands after power-up
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         pwr_cnt_reg  <= 17'h0;
         pwr_done_reg <= 1'b0;
      end else if (!pwr_done_reg) begin
         if (pwr_cnt_reg == 17'(POWERUP_CYCLES - 1)) begin
            pwr_done_reg <= 1'b1;
         end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 17'h1;
         end
      end
   end

   // quarter-bit divider for the serial clock
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN || state_reg == eep_pkg::EEP_MS_IDLE || tick) begin
         q_cnt_reg <= 7'h0;
      end else begin
         q_cnt_reg <= q_cnt_reg + 7'h1;
      end
   end

   // start, bit and stop sequencer
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         state_reg     <= eep_pkg::EEP_MS_IDLE;
         op_reg        <= eep_pkg::EEP_OP_START_WR;
         q_reg         <= 2'h0;
         bit_idx_reg   <= 4'h0;
         tx_reg        <= 8'h00;
         rx_reg        <= 8'h00;
         scl_reg       <= 1'b1;
         sda_oe_n_reg  <= 1'b1;
         rsp_valid_reg <= 1'b0;
         rsp_ack_reg   <= 1'b0;
      end else begin
         rsp_valid_reg <= 1'b0;
         if (cmd_take) begin
            op_reg      <= CMD_OP;
            q_reg       <= 2'h0;
            bit_idx_reg <= 4'h0;
            tx_reg      <= (CMD_OP == eep_pkg::EEP_OP_START_WR ||
                            CMD_OP == eep_pkg::EEP_OP_WRITE) ? CMD_DATA : `EEP_RELEASED;
            state_reg   <= (CMD_OP == eep_pkg::EEP_OP_START_WR) ? eep_pkg::EEP_MS_START :
                           (CMD_OP == eep_pkg::EEP_OP_STOP) ? eep_pkg::EEP_MS_STOP :
                           eep_pkg::EEP_MS_BIT;
         end else if (tick) begin
            q_reg <= q_reg + 2'h1;
            unique case (state_reg)
               eep_pkg::EEP_MS_IDLE: q_reg <= 2'h0;
               eep_pkg::EEP_MS_START: begin
                  unique case (q_reg)
                     2'h0: sda_oe_n_reg <= 1'b1;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_oe_n_reg <= 1'b0;
                     2'h3: begin
                        scl_reg   <= 1'b0;
                        state_reg <= eep_pkg::EEP_MS_BIT;
                     end
                  endcase
               end
               eep_pkg::EEP_MS_BIT: begin
                  unique case (q_reg)
                     2'h0: begin
                        if (bit_idx_reg == `EEP_BIT_ACK) begin
                           sda_oe_n_reg <= (op_reg != eep_pkg::EEP_OP_READ_ACK);
                        end else begin
                           sda_oe_n_reg <= tx_reg[7];
                        end
                     end
                     2'h1: scl_reg <= 1'b1;
                     2'h2: begin
                        if (bit_idx_reg == `EEP_BIT_ACK) begin
                           rsp_ack_reg <= ~sda_s_reg;
                        end else begin
                           rx_reg <= {rx_reg[6:0], sda_s_reg};
                           tx_reg <= {tx_reg[6:0], 1'b1};
                        end
                     end
                     2'h3: begin
                        scl_reg <= 1'b0;
                        if (bit_idx_reg == `EEP_BIT_ACK) begin
                           state_reg     <= eep_pkg::EEP_MS_IDLE;
                           rsp_valid_reg <= 1'b1;
                        end else begin
                           bit_idx_reg <= bit_idx_reg + 4'h1;
                        end
                     end
                  endcase
               end
               eep_pkg::EEP_MS_STOP: begin
                  unique case (q_reg)
                     2'h0: sda_oe_n_reg <= 1'b0;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_oe_n_reg <= 1'b1;
                     2'h3: state_reg <= eep_pkg::EEP_MS_IDLE;
                  endcase
               end
            endcase
         end
      end
   end

   assign link.scl          = scl_reg;
   assign link.mst_sda_o    = 1'b0;
   assign link.mst_sda_oe_n = sda_oe_n_reg;
   assign RSP_VALID         = rsp_valid_reg;
   assign RSP_DATA          = rx_reg;
   assign RSP_ACK           = rsp_ack_reg;

endmodule : eep_bus_mst

/* File: hdl/eep_mem_dev.sv */
// memory device end: two-wire slave, page buffer, program timer and array
// Contract
// - programming ends within 5 ms of stop
// - while programming, bus ignored, data released
// - master waits 1 ms after power-up
// - master makes clock, start and stop
// - data changes only while clock low
// - start is data falling, clock high
// - stop is data rising, clock high
// - address byte matches on upper 1010
// - address lsb one reads, zero writes
// - receiver pulls data low on ninth clock
// - acknowledge address and every written byte
// - read eight bits, continue on master ack
// - byte write programs on following stop
// - page write takes up to sixteen bytes
// - page data bumps only low address bits
// - excess page bytes wrap and overwrite
// - ack polling withheld while programming
// - protect high makes array read only
// - counter holds last address plus one
// - random read uses dummy write, restart
`timescale 1ns/1ps
`include "eep_params.svh"
module eep_mem_dev #(
   parameter int unsigned PROG_CYCLES = `EEP_PROG_CYCLES
) (
   input  logic       LINK_CLK,
   input  logic       RSTN,
   input  logic       WRITE_PROTECT,
   output logic       PROG_BUSY,
   eep_link_if.device link
);
   eep_pkg::eep_dev_state_type state_reg;
   eep_pkg::eep_rx_kind_type   kind_reg;
   logic [3:0]                 bit_cnt_reg;
   logic [7:0]                 shift_reg;
   logic                       rw_reg;
   logic                       master_ack_reg;
   logic                       sda_oe_n_reg;
   logic [10:0]                addr_reg;
   logic [7:0]                 page_buf [`EEP_PAGE_BYTES];
   logic [15:0]                mask_reg;
   logic [7:0]                 mem [`EEP_MEM_BYTES];
   logic                       prog_busy_reg;
   logic [16:0]                prog_cnt_reg;
   logic [6:0]                 prog_page_reg;
   logic                       scl_m_reg, scl_s_reg, scl_d_reg;
   logic                       sda_m_reg, sda_s_reg, sda_d_reg;
   logic                       wp_m_reg, wp_s_reg;
   logic                       start_cond, stop_cond, scl_rise, scl_fall;
   logic                       byte_done, id_match, slave_hit, word_take, data_take;
   logic                       tx_load, tx_done, prog_start, prog_done;
   logic [7:0]                 rd_byte;

   // link pin synchronisers
   always_ff @(posedge LINK_CLK) begin
      if (!RSTN) begin
         {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
         {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
         {wp_m_reg, wp_s_reg}              <= 2'h0;
      end else begin
         {scl_m_reg, scl_s_reg, scl_d_reg} <= {link.scl, scl_m_reg, scl_s_reg};
         {sda_m_reg, sda_s_reg, sda_d_reg} <= {link.sda, sda_m_reg, sda_s_reg};
         {wp_m_reg, wp_s_reg}              <= {WRITE_PROTECT, wp_m_reg};
      end
   end

   assign start_cond = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
   assign stop_cond  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
   assign scl_rise   = scl_s_reg & ~scl_d_reg;
   assign scl_fall   = ~scl_s_reg & scl_d_reg;
   assign byte_done  = (state_reg == eep_pkg::EEP_DS_RX) && scl_fall &&
                       (bit_cnt_reg == `EEP_BIT_ACK);
   assign id_match   = (shift_reg[`EEP_ID_MSB:`EEP_ID_LSB] == `EEP_DEV_ID);
   assign slave_hit  = byte_done && (kind_reg == eep_pkg::EEP_RK_SLAVE) && id_match;
   assign word_take  = byte_done && (kind_reg == eep_pkg::EEP_RK_WORD);
   assign data_take  = byte_done && (kind_reg == eep_pkg::EEP_RK_DATA);
   assign rd_byte    = mem[addr_reg];
   assign tx_load    = scl_fall &&
                       (((state_reg == eep_pkg::EEP_DS_RACK) &&
                         (kind_reg == eep_pkg::EEP_RK_SLAVE) && rw_reg) ||
                        ((state_reg == eep_pkg::EEP_DS_TACK) && master_ack_reg));
   assign tx_done    = (state_reg == eep_pkg::EEP_DS_TX) && scl_fall &&
                       (bit_cnt_reg == `EEP_BIT_TX_LAST);
   assign prog_start = stop_cond && !prog_busy_reg && (mask_reg != 16'h0000) &&
                       !wp_s_reg;
   assign prog_done  = prog_busy_reg && (prog_cnt_reg == 17'(PROG_CYCLES - 1));

   // byte-level protocol engine
   always_ff @(posedge LINK_CLK) begin
      if (!RSTN) begin
         state_reg      <= eep_pkg::EEP_DS_IDLE;
         kind_reg       <= eep_pkg::EEP_RK_SLAVE;
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         rw_reg         <= 1'b0;
         master_ack_reg <= 1'b0;
         sda_oe_n_reg   <= 1'b1;
      end else if (start_cond) begin
         state_reg    <= prog_busy_reg ? eep_pkg::EEP_DS_IDLE : eep_pkg::EEP_DS_RX;
         kind_reg     <= eep_pkg::EEP_RK_SLAVE;
         bit_cnt_reg  <= 4'h0;
         sda_oe_n_reg <= 1'b1;
      end else if (stop_cond) begin
         state_reg    <= eep_pkg::EEP_DS_IDLE;
         sda_oe_n_reg <= 1'b1;
      end else begin
         unique case (state_reg)
            eep_pkg::EEP_DS_IDLE, eep_pkg::EEP_DS_WAIT: sda_oe_n_reg <= 1'b1;
            eep_pkg::EEP_DS_RX: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_s_reg};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (byte_done) begin
                  if (kind_reg == eep_pkg::EEP_RK_SLAVE) begin
                     rw_reg <= shift_reg[`EEP_RW_BIT];
                  end
                  if (kind_reg == eep_pkg::EEP_RK_SLAVE && !id_match) begin
                     state_reg <= eep_pkg::EEP_DS_IDLE;
                  end else begin
                     state_reg    <= eep_pkg::EEP_DS_RACK;
                     sda_oe_n_reg <= 1'b0;
                  end
               end
            end
            eep_pkg::EEP_DS_RACK: begin
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (tx_load) begin
                     state_reg    <= eep_pkg::EEP_DS_TX;
                     shift_reg    <= rd_byte;
                     sda_oe_n_reg <= rd_byte[7];
                  end else begin
                     state_reg    <= eep_pkg::EEP_DS_RX;
                     sda_oe_n_reg <= 1'b1;
                     kind_reg     <= (kind_reg == eep_pkg::EEP_RK_SLAVE) ?
                                     eep_pkg::EEP_RK_WORD : eep_pkg::EEP_RK_DATA;
                  end
               end
            end
            eep_pkg::EEP_DS_TX: begin
               if (tx_done) begin
                  state_reg    <= eep_pkg::EEP_DS_TACK;
                  sda_oe_n_reg <= 1'b1;
               end else if (scl_fall) begin
                  shift_reg    <= {shift_reg[6:0], 1'b0};
                  sda_oe_n_reg <= shift_reg[6];
                  bit_cnt_reg  <= bit_cnt_reg + 4'h1;
               end
            end
            eep_pkg::EEP_DS_TACK: begin
               if (scl_rise) begin
                  master_ack_reg <= ~sda_s_reg;
               end else if (scl_fall) begin
                  if (tx_load) begin
                     state_reg    <= eep_pkg::EEP_DS_TX;
                     bit_cnt_reg  <= 4'h0;
                     shift_reg    <= rd_byte;
                     sda_oe_n_reg <= rd_byte[7];
                  end else begin
                     state_reg <= eep_pkg::EEP_DS_WAIT;
                  end
               end
            end
         endcase
      end
   end

   // address counter
   always_ff @(posedge LINK_CLK) begin
      if (!RSTN) begin
         addr_reg <= 11'h000;
      end else if (slave_hit) begin
         addr_reg[10:8] <= shift_reg[`EEP_UPPER_MSB:`EEP_UPPER_LSB];
      end else if (word_take) begin
         addr_reg[7:0] <= shift_reg;
      end else if (data_take) begin
         addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
      end else if (tx_done) begin
         addr_reg <= addr_reg + 11'h001;
      end
   end

   // page buffer and loaded-byte mask
   always_ff @(posedge LINK_CLK) begin
      if (!RSTN) begin
         mask_reg <= 16'h0000;
      end else if (start_cond && !prog_busy_reg) begin
         mask_reg <= 16'h0000;
      end else if (data_take) begin
         page_buf[addr_reg[3:0]] <= shift_reg;
         mask_reg[addr_reg[3:0]] <= 1'b1;
      end else if (prog_done) begin
         mask_reg <= 16'h0000;
      end
   end

   // self-timed program cycle
   always_ff @(posedge LINK_CLK) begin
      if (!RSTN) begin
         prog_busy_reg <= 1'b0;
         prog_cnt_reg  <= 17'h0;
         prog_page_reg <= 7'h00;
      end else if (prog_start) begin
         prog_busy_reg <= 1'b1;
         prog_cnt_reg  <= 17'h0;
         prog_page_reg <= addr_reg[10:4];
      end else if (prog_done) begin
         prog_busy_reg <= 1'b0;
      end else if (prog_busy_reg) begin
         prog_cnt_reg <= prog_cnt_reg + 17'h1;
      end
   end

   // array commit of every loaded page byte at cycle end
   always_ff @(posedge LINK_CLK) begin
      if (prog_done) begin
         for (int i = 0; i < `EEP_PAGE_BYTES; i++) begin
            if (mask_reg[i]) begin
               mem[{prog_page_reg, 4'(i)}] <= page_buf[i];
            end
         end
      end
   end

   assign link.dev_sda_o    = 1'b0;
   assign link.dev_sda_oe_n = sda_oe_n_reg;
   assign PROG_BUSY         = prog_busy_reg;

endmodule : eep_mem_dev

/* File: testbench/eep_link_monitor.sv */
// checker for the two-wire link between bus master and memory device
`timescale 1ns/1ps
module eep_link_monitor #(
   parameter int unsigned PROG_CYCLES = 200
) (
   input logic LINK_CLK,
   input logic RSTN,
   input logic WRITE_PROTECT,
   input logic PROG_BUSY,
   input logic scl,
   input logic sda,
   input logic dev_sda_oe_n
);
   logic        scl_reg;
   logic        sda_reg;
   logic        seen_reg;
   logic        busy_st_reg;
   logic        wr_reg;
   logic        rd_reg;
   logic [3:0]  bit_reg;
   logic [1:0]  byte_reg;
   logic [7:0]  sh_reg;
   logic [31:0] cnt_reg;
   logic        start_ev;
   logic        stop_ev;
   logic        rise;
   logic        ack9;

   assign start_ev = scl_reg & scl & sda_reg & ~sda;
   assign stop_ev  = scl_reg & scl & ~sda_reg & sda;
   assign rise     = scl & ~scl_reg;
   assign ack9     = rise & (bit_reg == 4'h8);

   // line history, shift register and program length
   always_ff @(posedge LINK_CLK) begin
      scl_reg <= RSTN ? scl : 1'b1;
      sda_reg <= RSTN ? sda : 1'b1;
      cnt_reg <= (RSTN & PROG_BUSY) ? cnt_reg + 32'h1 : 32'h0;
      if (rise) sh_reg <= {sh_reg[6:0], sda};
   end

   // framing: bit and byte position, selection
   always_ff @(posedge LINK_CLK) begin
      if (!RSTN || stop_ev || start_ev) begin
         bit_reg  <= 4'h0;
         byte_reg <= 2'h0;
         wr_reg   <= 1'b0;
         rd_reg   <= 1'b0;
      end else if (ack9) begin
         bit_reg  <= 4'h0;
         byte_reg <= (byte_reg == 2'h3) ? 2'h3 : byte_reg + 2'h1;
         if (byte_reg == 2'h0) begin
            wr_reg <= (sh_reg[7:4] == 4'ha) & ~sh_reg[0] & ~busy_st_reg;
            rd_reg <= (sh_reg[7:4] == 4'ha) & sh_reg[0] & ~busy_st_reg;
         end
      end else if (rise) begin
         bit_reg <= bit_reg + 4'h1;
      end
   end

   always_ff @(posedge LINK_CLK) begin
      if (!RSTN) begin
         seen_reg    <= 1'b0;
         busy_st_reg <= 1'b0;
      end else if (start_ev) begin
         seen_reg    <= 1'b1;
         busy_st_reg <= PROG_BUSY;
      end
   end

   default clocking cb @(posedge LINK_CLK); endclocking
   default disable iff (!RSTN);

   property p_busy_len;
      $fell(PROG_BUSY) |-> cnt_reg >= PROG_CYCLES - 1 && cnt_reg <= PROG_CYCLES + 1;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("program cycle length wrong");
   property p_busy_quiet;
      PROG_BUSY |-> dev_sda_oe_n;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("data driven while busy");
   property p_dev_low;
      $changed(dev_sda_oe_n) |-> !scl;
   endproperty
   a_dev_low: assert property (p_dev_low) else $error("device data moved, clock high");
   property p_no_start;
      !seen_reg |-> dev_sda_oe_n;
   endproperty
   a_no_start: assert property (p_no_start) else $error("device active before start");
   property p_addr_nack;
      ack9 && byte_reg == 2'h0 && sh_reg[7:4] != 4'ha |-> dev_sda_oe_n;
   endproperty
   a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked");
   property p_ack_hold;
      ack9 && !dev_sda_oe_n |=> !dev_sda_oe_n [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped, clock high");
   property p_addr_ack;
      ack9 && byte_reg == 2'h0 && sh_reg[7:4] == 4'ha && !busy_st_reg |-> !dev_sda_oe_n;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
   property p_wr_ack;
      ack9 && byte_reg != 2'h0 && wr_reg |-> !dev_sda_oe_n;
   endproperty
   a_wr_ack: assert property (p_wr_ack) else $error("written byte not acked");
   property p_rd_rel;
      ack9 && byte_reg != 2'h0 && rd_reg |-> dev_sda_oe_n;
   endproperty
   a_rd_rel: assert property (p_rd_rel) else $error("data held in ack slot");
   property p_prog;
      stop_ev && wr_reg && byte_reg == 2'h3 && !WRITE_PROTECT |-> ##[1:8] PROG_BUSY;
   endproperty
   a_prog: assert property (p_prog) else $error("no program cycle after stop");
   property p_poll;
      ack9 && busy_st_reg |-> dev_sda_oe_n;
   endproperty
   a_poll: assert property (p_poll) else $error("acked while programming");
   property p_prot;
      $rose(PROG_BUSY) |-> !$past(WRITE_PROTECT, 3);
   endproperty
   a_prot: assert property (p_prot) else $error("programmed while protected");
endmodule : eep_link_monitor

/* File: testbench/tb.sv */
// testbench: bus master and memory device joined over the two-wire link
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      eep_pkg::eep_op_type op;
      logic [7:0]          d;
      logic [2:0]          f;
      logic [8:0]          q;
   } eep_row_type;
   localparam eep_pkg::eep_op_type op_st = eep_pkg::EEP_OP_START_WR;
   localparam eep_pkg::eep_op_type op_wr = eep_pkg::EEP_OP_WRITE;
   localparam eep_pkg::eep_op_type op_ra = eep_pkg::EEP_OP_READ_ACK;
   localparam eep_pkg::eep_op_type op_rn = eep_pkg::EEP_OP_READ_NACK;
   localparam eep_pkg::eep_op_type op_sp = eep_pkg::EEP_OP_STOP;
   localparam int unsigned         prog   = 200;
   // flags: protect, expected ack, expected busy; q[8] asks for a data compare
   localparam eep_row_type rows [17] = '{
      '{op_st, 8'hae, 3'b010, 9'h000},
      '{op_wr, 8'hfe, 3'b010, 9'h000},
      '{op_wr, 8'h3c, 3'b010, 9'h000},
      '{op_sp, 8'h00, 3'b001, 9'h000},
      '{op_st, 8'hae, 3'b000, 9'h000},
      '{op_sp, 8'h00, 3'b000, 9'h000},
      '{op_st, 8'hae, 3'b110, 9'h000},
      '{op_wr, 8'hfe, 3'b110, 9'h000},
      '{op_wr, 8'h99, 3'b110, 9'h000},
      '{op_sp, 8'h00, 3'b100, 9'h000},
      '{op_st, 8'hae, 3'b010, 9'h000},
      '{op_wr, 8'hfe, 3'b010, 9'h000},
      '{op_st, 8'haf, 3'b010, 9'h000},
      '{op_rn, 8'h00, 3'b000, 9'h13c},
      '{op_sp, 8'h00, 3'b000, 9'h000},
      '{op_st, 8'h5e, 3'b000, 9'h000},
      '{op_sp, 8'h00, 3'b000, 9'h000}};
   logic                clk_sys;
   logic                link_clk;
   logic                rstn;
   logic                wp;
   logic                cmd_valid;
   logic                cmd_ready;
   eep_pkg::eep_op_type cmd_op;
   logic [7:0]          cmd_data;
   logic [7:0]          rsp_data;
   logic                rsp_valid;
   logic                rsp_ack;
   logic                prog_busy;
   logic [8:0]          wire_sh;
   int                  fails;
   int                  total_checks;
   int                  n;
   eep_link_if          link ();

   eep_bus_mst #(.POWERUP_CYCLES(20)) i_eep_bus_mst (
      .CLK_SYS(clk_sys), .RSTN(rstn), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
      .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
      .RSP_ACK(rsp_ack), .link(link.master));
   eep_mem_dev #(.PROG_CYCLES(prog)) i_eep_mem_dev (
      .LINK_CLK(link_clk), .RSTN(rstn), .WRITE_PROTECT(wp), .PROG_BUSY(prog_busy),
      .link(link.device));
   eep_link_monitor #(.PROG_CYCLES(prog)) i_eep_link_monitor (
      .LINK_CLK(link_clk), .RSTN(rstn), .WRITE_PROTECT(wp), .PROG_BUSY(prog_busy),
      .scl(link.scl), .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n));

   initial clk_sys = 1'b0;
   always #4 clk_sys = ~clk_sys;
   initial begin
      link_clk = 1'b0;
      #5;
      forever #32 link_clk = ~link_clk;
   end
   // bits as seen on the wire at each clock rise
   always @(posedge link.scl) wire_sh <= {wire_sh[7:0], link.sda};

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic op(input eep_pkg::eep_op_type o, input logic [7:0] d);
      int k = 0;
      do @(negedge clk_sys); while (cmd_ready !== 1'b1 && ++k < 20000);
      cmd_op    = o;
      cmd_data  = d;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      k = 0;
      if (o == op_sp) while (cmd_ready !== 1'b1 && k++ < 2000) @(negedge clk_sys);
      else while (rsp_valid !== 1'b1 && k++ < 6000) @(negedge clk_sys);
      chk({7'h0, (o == op_sp) ? cmd_ready : rsp_valid}, 8'h01);
   endtask : op

   task automatic do_reset;
      rstn = 1'b0;
      repeat (8) @(posedge link_clk);
      @(negedge clk_sys);
      chk({6'h0, link.scl, link.sda}, 8'h03);
      chk({6'h0, cmd_ready, prog_busy}, 8'h00);
      rstn = 1'b1;
      @(negedge clk_sys);
      chk({7'h0, cmd_ready}, 8'h00);
   endtask : do_reset

   task automatic final_report;
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (400000) @(posedge clk_sys);
      fails++;
      final_report();
   end

   initial begin
      fails        = 0;
      total_checks = 0;
      wp           = 1'b0;
      cmd_valid    = 1'b0;
      cmd_op       = op_sp;
      cmd_data     = 8'h00;
      do_reset();
      foreach (rows[i]) begin
         wp = rows[i].f[2];
         op(rows[i].op, rows[i].d);
         if (rows[i].op != op_sp) chk({7'h0, rsp_ack}, {7'h0, rows[i].f[1]});
         if (rows[i].op == op_st) chk(wire_sh[8:1], rows[i].d);
         if (rows[i].q[8]) chk(rsp_data, rows[i].q[7:0]);
         chk({7'h0, prog_busy}, {7'h0, rows[i].f[0]});
      end
      // page of 17 bytes from the last location: the pointer wraps in the page
      op(op_st, 8'hae);
      op(op_wr, 8'hff);
      for (int i = 0; i < 17; i++) begin
         op(op_wr, 8'h40 + 8'(i));
         chk({7'h0, rsp_ack}, 8'h01);
      end
      op(op_sp, 8'h00);
      chk({7'h0, prog_busy}, 8'h01);
      n = 0;
      while (prog_busy !== 1'b0 && n++ < 5000) @(negedge clk_sys);
      chk({7'h0, prog_busy}, 8'h00);
      op(op_st, 8'hae);
      op(op_wr, 8'hfe);
      op(op_st, 8'haf);
      op(op_ra, 8'h00);
      chk(rsp_data, 8'h4f);
      chk({7'h0, rsp_ack}, 8'h01);
      op(op_rn, 8'h00);
      chk(rsp_data, 8'h50);
      chk({7'h0, rsp_ack}, 8'h00);
      op(op_sp, 8'h00);
      do_reset();
      op(op_st, 8'hae);
      chk({7'h0, rsp_ack}, 8'h01);
      op(op_sp, 8'h00);
      final_report();
   end
endmodule : tb
